//--- pkg/mrp_pkg.sv
// Constants, types and helpers shared by the region protection checker
`default_nettype none
package mrp_pkg;
  localparam int NUM_REGIONS = 8;
  localparam int RIDX_W = 3;
  localparam bit UNIT_PRESENT = 1'b1;
  localparam int AXI_AW = 8;

  localparam logic [7:0] OFS_TYPE = 8'h90;
  localparam logic [7:0] OFS_CTRL = 8'h94;
  localparam logic [7:0] OFS_RNR = 8'h98;
  localparam logic [7:0] OFS_RBAR = 8'h9C;
  localparam logic [7:0] OFS_RASR = 8'hA0;
  localparam logic [7:0] OFS_FSTAT = 8'hA8;
  localparam logic [7:0] OFS_FADDR = 8'hAC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int TYPE_DREG_LO = 8;
  localparam int CTRL_EN = 0;
  localparam int CTRL_HFNMI = 1;
  localparam int CTRL_PRIVDEF = 2;
  localparam int CTRL_W = 3;
  localparam int RBAR_VALID = 4;
  localparam logic [31:0] RBAR_MASK = 32'hFFFF_FFE0;
  localparam logic [31:0] RASR_MASK = 32'h173F_FF3F;
  localparam int RASR_EN = 0;
  localparam int RASR_SIZE_LO = 1;
  localparam int RASR_SIZE_W = 5;
  localparam int RASR_SRD_LO = 8;
  localparam int RASR_B = 16;
  localparam int RASR_C = 17;
  localparam int RASR_S = 18;
  localparam int RASR_TEX_LO = 19;
  localparam int RASR_AP_LO = 24;
  localparam int RASR_XN = 28;

  localparam logic [5:0] SIZE_MIN_LSB = 6'h08;
  localparam logic [5:0] SIZE_MAX_LSB = 6'h20;
  localparam logic [5:0] SUB_SHIFT = 6'h03;
  localparam logic [11:0] PPB_TAG = 12'hE00;
  localparam logic [31:0] SYS_SPACE_BASE = 32'hE000_0000;

  localparam logic [2:0] AP_NONE = 3'h0;
  localparam logic [2:0] AP_PRW = 3'h1;
  localparam logic [2:0] AP_PRW_URO = 3'h2;
  localparam logic [2:0] AP_FULL = 3'h3;
  localparam logic [2:0] AP_PRO = 3'h5;
  localparam logic [2:0] AP_RO = 3'h6;
  localparam logic [2:0] AP_RO_ALT = 3'h7;

  localparam logic [1:0] CACHE_NONE = 2'h0;
  localparam logic [1:0] CACHE_WBWA = 2'h1;
  localparam logic [1:0] CACHE_WT = 2'h2;

  localparam int FST_FAULT = 0;
  localparam int FST_FETCH = 1;
  localparam int FST_WRITE = 2;
  localparam int FST_W = 3;

  typedef enum logic [1:0] {MEM_STRONG, MEM_DEVICE, MEM_NORMAL} mrp_mem_e;

  typedef struct packed {
    logic [31:0] addr;
    logic priv;
    logic write;
    logic fetch;
    logic vect;
    logic hfnmi;
  } mrp_acc_s;

  typedef struct packed {
    mrp_mem_e mtype;
    logic [1:0] cache;
    logic share;
    logic xn;
    logic [2:0] ap;
  } mrp_attr_s;

  typedef struct packed {
    logic grant;
    logic fault;
    logic [31:0] paddr;
    mrp_attr_s attr;
  } mrp_dec_s;

  // Fixed default system map, by address eighth
  function automatic mrp_attr_s def_attr(input logic [31:0] addr);
    mrp_attr_s a;
    a = '{MEM_NORMAL, CACHE_WBWA, 1'b0, 1'b0, AP_FULL};
    unique case (addr[31:29])
      3'h0: a.cache = CACHE_WT;
      3'h1, 3'h3: a.cache = CACHE_WBWA;
      3'h4: a.cache = CACHE_WT;
      3'h2, 3'h5, 3'h6: begin
        a = '{MEM_DEVICE, CACHE_NONE, 1'b0, 1'b1, AP_FULL};
      end
      3'h7: begin
        a = '{MEM_DEVICE, CACHE_NONE, 1'b0, 1'b1, AP_FULL};
        if (addr[31:20] == PPB_TAG) begin
          a.mtype = MEM_STRONG;
        end
      end
    endcase
    return a;
  endfunction

  function automatic logic perm_ok(input logic [2:0] ap, input logic priv,
                                   input logic write);
    logic ok;
    ok = 1'b0;
    unique case (ap)
      AP_PRW: ok = priv;
      AP_PRW_URO: ok = priv || !write;
      AP_FULL: ok = 1'b1;
      AP_PRO: ok = priv && !write;
      AP_RO, AP_RO_ALT: ok = !write;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

//--- design/mrp_region_hit.sv
// Address match of one programmed region, with sub-region disables
`default_nettype none
module mrp_region_hit
  import mrp_pkg::*;
(
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_base,
  input wire logic [31:0] i_rasr,
  output logic o_hit
);
  logic [5:0] lsb;
  logic [31:0] mask;
  logic [2:0] sub;
  logic inrange;

  always_comb begin
    // Boundary bit is size field plus one
    lsb = {1'b0, i_rasr[RASR_SIZE_LO +: RASR_SIZE_W]} + 6'h01;
    // Natural alignment: bits below the boundary are ignored
    mask = (lsb >= SIZE_MAX_LSB) ? 32'h0 : (32'hFFFF_FFFF << lsb);
    inrange = ((i_addr ^ i_base) & mask) == 32'h0;
    sub = 3'(i_addr >> (lsb - SUB_SHIFT));
    o_hit = i_rasr[RASR_EN] && (lsb >= SIZE_MIN_LSB) && inrange
            && !i_rasr[RASR_SRD_LO + int'(sub)];
  end
endmodule
`default_nettype wire

//--- design/mrp_attr_decode.sv
// Decodes a region's type, cache, share, access and execute-never bits
`default_nettype none
module mrp_attr_decode
  import mrp_pkg::*;
(
  input wire logic [31:0] i_rasr,
  output mrp_attr_s o_attr,
  output logic o_valid
);
  logic [4:0] texcb;

  always_comb begin
    texcb = {i_rasr[RASR_TEX_LO +: 3], i_rasr[RASR_C], i_rasr[RASR_B]};
    o_attr.ap = i_rasr[RASR_AP_LO +: 3];
    o_attr.xn = i_rasr[RASR_XN];
    o_attr.mtype = MEM_STRONG;
    o_attr.cache = CACHE_NONE;
    o_attr.share = 1'b1;
    o_valid = 1'b1;
    unique casez (texcb)
      5'b00000: o_attr.mtype = MEM_STRONG;
      5'b00001: o_attr.mtype = MEM_DEVICE;
      5'b0001?: begin
        o_attr.mtype = MEM_NORMAL;
        o_attr.cache = texcb[1:0];
        o_attr.share = i_rasr[RASR_S];
      end
      // Reserved encodings refuse the access
      default: o_valid = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- design/mrp_checker.sv
// Region protection checker: register file and per-access decision
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
// Operation
// - Physical address equals requested address; no remapping.
// - Protection off or absent: default map for everything.
// - Private peripheral region always uses the default map.
// - Vector-table reads on exception entry use the default map.
// - System space is execute-never; fetches there are refused.
// - Device system space may become strongly-ordered, never normal.
// - Config bit makes fault and NMI handlers use the regions; with it clear they use the default map.
// - Privileged background region ranks below every programmed region.
// - Highest-numbered hit region supplies attributes and permissions.
// - No valid hit and no default case: refuse and flag fault.
// - One region map serves fetches and data alike.
// - Region execute-never refuses fetches resolving to it.
// - Region size is two to the N, N from 8 to 32.
// - Each region splits into eight separately disableable sub-regions.
// - Disabled sub-region is no hit for its region.
// - Region count is a fixed build parameter.
// - Every access is compared against all programmed regions.
// - Private peripheral region detected from upper twelve address bits.
// - Match boundary is size plus one; three bits below pick sub-region.
// - Any violation raises the severe fault exception.
module mrp_checker
  import mrp_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [AXI_AW-1:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [AXI_AW-1:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_ACC_VALID,
  input wire mrp_acc_s I_ACC,
  output logic O_DEC_VALID,
  output mrp_dec_s O_DEC,
  output logic O_SEVERE_FAULT
);
  typedef struct packed {
    logic [NUM_REGIONS-1:0][31:0] rbar;
    logic [NUM_REGIONS-1:0][31:0] rasr;
    logic [CTRL_W-1:0] ctrl;
    logic [RIDX_W-1:0] rnr;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic bvalid;
    logic rvalid;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [FST_W-1:0] fstat;
    logic [31:0] faddr;
    logic dec_valid;
    mrp_dec_s dec;
    logic severe;
  } mrp_st_s;

  mrp_st_s st;
  mrp_st_s next_st;

  // Region comparators, one per region, all evaluated every access
  logic [NUM_REGIONS-1:0] hit_vec;
  for (genvar r = 0; r < NUM_REGIONS; r++) begin : g_reg
    mrp_region_hit u_hit (
      .i_addr(I_ACC.addr),
      .i_base(st.rbar[r]),
      .i_rasr(st.rasr[r]),
      .o_hit(hit_vec[r])
    );
  end

  logic [RIDX_W-1:0] win;
  logic any_hit;

  always_comb begin
    win = '0;
    any_hit = 1'b0;
    // Later, higher-numbered hits overwrite lower ones
    for (int r = 0; r < NUM_REGIONS; r++) begin
      if (hit_vec[r]) begin
        win = RIDX_W'(r);
        any_hit = 1'b1;
      end
    end
  end

  mrp_attr_s reg_attr;
  logic reg_attr_ok;

  mrp_attr_decode u_dec (
    .i_rasr(st.rasr[win]),
    .o_attr(reg_attr),
    .o_valid(reg_attr_ok)
  );

  // Access decision
  mrp_attr_s dflt;
  mrp_attr_s attr;
  logic private_peripheral_region;
  logic sys;
  logic use_def;
  logic ok;

  always_comb begin
    dflt = def_attr(I_ACC.addr);
    private_peripheral_region = I_ACC.addr[31:20] == PPB_TAG;
    sys = I_ACC.addr >= SYS_SPACE_BASE;
    use_def = !UNIT_PRESENT || !st.ctrl[CTRL_EN]
              || private_peripheral_region
              || I_ACC.vect
              || (!st.ctrl[CTRL_HFNMI] && I_ACC.hfnmi);
    attr = dflt;
    ok = 1'b1;
    if (use_def) begin
      ok = 1'b1;
    end else if (any_hit) begin
      attr = reg_attr;
      ok = reg_attr_ok && perm_ok(reg_attr.ap, I_ACC.priv, I_ACC.write);
      // Device system space may be strongly-ordered, not normal
      if (sys && dflt.mtype == MEM_DEVICE && reg_attr.mtype == MEM_NORMAL) begin
        attr.mtype = MEM_DEVICE;
        attr.cache = CACHE_NONE;
      end
      if (sys) begin
        attr.xn = 1'b1;
      end
    end else if (st.ctrl[CTRL_PRIVDEF] && I_ACC.priv) begin
      ok = 1'b1;
    end else begin
      ok = 1'b0;
    end
    if (I_ACC.fetch && (attr.xn || sys)) begin
      ok = 1'b0;
    end
  end

  // Register read view
  logic [31:0] rd_word;
  logic rd_ok;

  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    unique case (I_ARADDR)
      OFS_TYPE: begin
        if (UNIT_PRESENT) begin
          rd_word[TYPE_DREG_LO +: 8] = 8'(NUM_REGIONS);
        end
      end
      OFS_CTRL: rd_word[CTRL_W-1:0] = st.ctrl;
      OFS_RNR: rd_word[RIDX_W-1:0] = st.rnr;
      OFS_RBAR: rd_word = st.rbar[st.rnr] | 32'(st.rnr);
      OFS_RASR: rd_word = st.rasr[st.rnr];
      OFS_FSTAT: rd_word[FST_W-1:0] = st.fstat;
      OFS_FADDR: rd_word = st.faddr;
      default: rd_ok = 1'b0;
    endcase
  end

  logic [31:0] wval;
  logic [FST_W-1:0] fset;
  logic [FST_W-1:0] fclr;
  logic wr_go;
  logic wr_ok;

  always_comb begin
    next_st = st;
    fclr = '0;
    wr_ok = 1'b1;
    wval = 32'h0;
    wr_go = !st.aw_rdy && !st.w_rdy && !st.bvalid;

    // Write address and data, taken in either order
    if (I_AWVALID && st.aw_rdy) begin
      next_st.aw_rdy = 1'b0;
      next_st.awaddr = I_AWADDR;
    end
    if (I_WVALID && st.w_rdy) begin
      next_st.w_rdy = 1'b0;
      next_st.wdata = I_WDATA;
      next_st.wstrb = I_WSTRB;
    end

    if (wr_go) begin
      unique case (st.awaddr)
        OFS_CTRL: begin
          wval = strb_merge(32'(st.ctrl), st.wdata, st.wstrb);
          next_st.ctrl = UNIT_PRESENT ? wval[CTRL_W-1:0] : '0;
        end
        OFS_RNR: begin
          wval = strb_merge(32'(st.rnr), st.wdata, st.wstrb);
          next_st.rnr = wval[RIDX_W-1:0];
        end
        OFS_RBAR: begin
          wval = strb_merge(st.rbar[st.rnr], st.wdata, st.wstrb);
          if (wval[RBAR_VALID]) begin
            next_st.rnr = wval[RIDX_W-1:0];
            next_st.rbar[wval[RIDX_W-1:0]] = wval & RBAR_MASK;
          end else begin
            next_st.rbar[st.rnr] = wval & RBAR_MASK;
          end
        end
        OFS_RASR: begin
          wval = strb_merge(st.rasr[st.rnr], st.wdata, st.wstrb);
          next_st.rasr[st.rnr] = wval & RASR_MASK;
        end
        OFS_FSTAT: begin
          wval = strb_merge(32'h0, st.wdata, st.wstrb);
          fclr = wval[FST_W-1:0];
        end
        OFS_TYPE, OFS_FADDR: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    if (st.bvalid && I_BREADY) begin
      next_st.bvalid = 1'b0;
      next_st.aw_rdy = 1'b1;
      next_st.w_rdy = 1'b1;
    end

    // Reads answer one cycle after the address is taken
    if (I_ARVALID && st.ar_rdy) begin
      next_st.ar_rdy = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.rvalid && I_RREADY) begin
      next_st.rvalid = 1'b0;
      next_st.ar_rdy = 1'b1;
    end

    // Decision registered one cycle after the request
    next_st.dec_valid = I_ACC_VALID;
    next_st.severe = I_ACC_VALID && !ok;
    fset = '0;
    if (I_ACC_VALID) begin
      next_st.dec.grant = ok;
      next_st.dec.fault = !ok;
      next_st.dec.paddr = I_ACC.addr;
      next_st.dec.attr = attr;
      if (!ok) begin
        fset[FST_FAULT] = 1'b1;
        fset[FST_FETCH] = I_ACC.fetch;
        fset[FST_WRITE] = I_ACC.write;
        next_st.faddr = I_ACC.addr;
      end
    end
    // A new fault outranks a clear in the same cycle
    next_st.fstat = (st.fstat & ~fclr) | fset;
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      st <= '0;
      st.aw_rdy <= 1'b1;
      st.w_rdy <= 1'b1;
      st.ar_rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign O_AWREADY = st.aw_rdy;
  assign O_WREADY = st.w_rdy;
  assign O_BVALID = st.bvalid;
  assign O_BRESP = st.bresp;
  assign O_ARREADY = st.ar_rdy;
  assign O_RVALID = st.rvalid;
  assign O_RDATA = st.rdata;
  assign O_RRESP = st.rresp;
  assign O_DEC_VALID = st.dec_valid;
  assign O_DEC = st.dec;
  assign O_SEVERE_FAULT = st.severe;
endmodule
`default_nettype wire

//--- tb/mrp_prot_checker.sv
// Concurrent checks on the access decision port of the protection checker
`default_nettype none
module mrp_prot_chk
  import mrp_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic I_ACC_VALID,
  input wire mrp_acc_s I_ACC,
  input wire logic O_DEC_VALID,
  input wire mrp_dec_s O_DEC,
  input wire logic O_SEVERE_FAULT
);
  default clocking @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);
  a_dec_next: assert property (I_ACC_VALID |=> O_DEC_VALID)
    else $error("decision pulse missing after request");
  a_addr_passed: assert property (
    I_ACC_VALID |=> O_DEC.paddr == $past(I_ACC.addr))
    else $error("physical address differs from requested address");
  a_fault_pulse: assert property (
    O_SEVERE_FAULT == (O_DEC_VALID && O_DEC.fault))
    else $error("severe fault pulse does not follow refused decision");
  a_grant_excl: assert property (O_DEC_VALID |-> O_DEC.grant != O_DEC.fault)
    else $error("decision neither grant nor fault alone");
  a_sys_noexec: assert property (
    I_ACC_VALID && I_ACC.fetch && I_ACC.addr[31:28] >= 4'hE |=> O_DEC.fault)
    else $error("fetch from system space not refused");
  a_xn_fetch: assert property (
    I_ACC_VALID && I_ACC.fetch |=> !(O_DEC.grant && O_DEC.attr.xn))
    else $error("fetch granted from execute-never memory");
  a_periph_map: assert property (
    I_ACC_VALID && I_ACC.addr[31:20] == PPB_TAG && !I_ACC.fetch
    |=> O_DEC.grant && O_DEC.attr.mtype == MEM_STRONG)
    else $error("peripheral access not served by default map");
  a_vector_map: assert property (
    I_ACC_VALID && I_ACC.vect && !I_ACC.fetch && I_ACC.addr[31:29] == 3'h0
    |=> O_DEC.grant)
    else $error("vector read not served by default map");
endmodule

bind mrp_checker mrp_prot_chk u_prot_chk (
  .I_CLOCK(I_CLOCK),
  .I_RST_N(I_RST_N),
  .I_ACC_VALID(I_ACC_VALID),
  .I_ACC(I_ACC),
  .O_DEC_VALID(O_DEC_VALID),
  .O_DEC(O_DEC),
  .O_SEVERE_FAULT(O_SEVERE_FAULT)
);
`default_nettype wire

//--- tb/mrp_core_model.sv
// Processor core model issuing one access at a time
`default_nettype none
module mrp_core_model
  import mrp_pkg::*;
(
  input wire logic clk,
  output logic acc_valid,
  output mrp_acc_s acc,
  input wire logic dec_valid,
  input wire mrp_dec_s dec,
  input wire logic fault
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    acc_valid = 1'b0;
    acc = '0;
  end
  // Request for one cycle, answer looked at in the cycle after
  task automatic issue(input mrp_acc_s a, output mrp_dec_s d, output logic f,
                       output logic v);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc <= a;
    @(posedge clk);
    acc_valid <= 1'b0;
    acc <= ~a;
    #1;
    d = dec;
    f = fault;
    v = dec_valid;
  endtask
endmodule
`default_nettype wire

//--- tb/mrp_checker_test.sv
// Self-checking bench for the region protection checker
`default_nettype none
module mrp_checker_test
  import mrp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] UR = 5'h00, PR = 5'h10, WR = 5'h08, FE = 5'h04, VE = 5'h02;
  localparam logic [4:0] HF = 5'h01;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, acc_valid, dec_valid, fault;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  mrp_acc_s acc;
  mrp_dec_s dec;
  int fail_count = 0;
  int checks_done = 0;
  always #2 clk = ~clk;

  mrp_checker dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
    .I_WSTRB(4'hF), .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .I_ACC_VALID(acc_valid),
    .I_ACC(acc), .O_DEC_VALID(dec_valid), .O_DEC(dec), .O_SEVERE_FAULT(fault));
  mrp_core_model core (.clk(clk), .acc_valid(acc_valid), .acc(acc), .dec_valid(dec_valid),
    .dec(dec), .fault(fault));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 20);
    bready <= 1'b0;
    if (!bvalid) begin
      fail_count++;
      print_verdict();
    end
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 20);
    rready <= 1'b0;
    if (!rvalid) begin
      fail_count++;
      print_verdict();
    end
    d = rdata;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  // Base with region select bit, then size and attributes; bases are aligned
  task automatic prog(input logic [31:0] rbar, input logic [31:0] rasr);
    axi_wr(OFS_RBAR, rbar, RESP_OKAY);
    axi_wr(OFS_RASR, rasr, RESP_OKAY);
  endtask
  task automatic ac(input logic [31:0] a, input logic [4:0] f, input logic eg,
                    output mrp_dec_s d);
    logic sf, v;
    core.issue(mrp_acc_s'({a, f}), d, sf, v);
    chk("dec_valid", {31'h0, v}, 32'h1);
    chk("paddr", d.paddr, a);
    chk("grant", {31'h0, d.grant}, {31'h0, eg});
    chk("fault", {30'h0, d.fault, sf}, {30'h0, !eg, !eg});
  endtask

  task automatic t_regs();
    logic [31:0] r;
    axi_rd(OFS_TYPE, RESP_OKAY, r);
    chk("type", r, 32'(NUM_REGIONS) << TYPE_DREG_LO);
    axi_rd(OFS_CTRL, RESP_OKAY, r);
    chk("ctrl", r, 32'h0);
    axi_rd(8'h00, RESP_SLVERR, r);
    axi_wr(8'h04, 32'hFFFF_FFFF, RESP_SLVERR);
  endtask
  task automatic t_off();
    mrp_dec_s d;
    ac(32'h4000_0000, PR | WR, 1'b1, d);
    chk("mtype", 32'(d.attr.mtype), 32'(MEM_DEVICE));
    ac(32'h0000_0100, FE, 1'b1, d);
    ac(32'hE000_0100, PR | FE, 1'b0, d);
  endtask
  task automatic t_regions();
    mrp_dec_s d;
    prog(32'h2000_0010, 32'h0302_0017);
    prog(32'h2000_0011, 32'h1502_0013);
    axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
    ac(32'h2000_0800, UR, 1'b1, d);
    chk("mtype", 32'(d.attr.mtype), 32'(MEM_NORMAL));
    ac(32'h2000_0800, FE, 1'b1, d);
    ac(32'h2000_0100, UR, 1'b0, d);
    ac(32'h2000_0100, PR, 1'b1, d);
    chk("xn", {31'h0, d.attr.xn}, 32'h1);
    ac(32'h2000_0100, PR | FE, 1'b0, d);
    ac(32'h3000_0000, PR, 1'b0, d);
  endtask
  task automatic t_special();
    mrp_dec_s d;
    ac(32'hE000_ED00, UR, 1'b1, d);
    chk("mtype", 32'(d.attr.mtype), 32'(MEM_STRONG));
    ac(32'h0000_0008, VE, 1'b1, d);
    ac(32'h3000_0000, PR | HF, 1'b1, d);
    axi_wr(OFS_CTRL, 32'h3, RESP_OKAY);
    ac(32'h3000_0000, PR | HF, 1'b0, d);
  endtask
  task automatic t_sub();
    mrp_dec_s d;
    prog(32'h2000_0010, 32'h0302_0417);
    ac(32'h2000_0400, UR, 1'b0, d);
    ac(32'h2000_0600, UR, 1'b1, d);
    axi_wr(OFS_CTRL, 32'h5, RESP_OKAY);
    ac(32'h2000_0400, PR, 1'b1, d);
    ac(32'h2000_0400, UR, 1'b0, d);
    ac(32'h2000_0100, PR | WR, 1'b0, d);
  endtask
  task automatic t_size();
    mrp_dec_s d;
    logic [31:0] r;
    prog(32'h0000_0016, 32'h0302_003F);
    prog(32'h4000_0017, 32'h0002_000F);
    axi_rd(OFS_RASR, RESP_OKAY, r);
    chk("rasr", r, 32'h0002_000F);
    ac(32'h4000_0080, PR, 1'b0, d);
    axi_rd(OFS_FADDR, RESP_OKAY, r);
    chk("faddr", r, 32'h4000_0080);
    ac(32'h4000_0100, PR, 1'b1, d);
    ac(32'h2000_0100, UR | WR, 1'b1, d);
    // Normal region over device system space keeps device type
    ac(32'hF000_0000, PR, 1'b1, d);
    chk("mtype", 32'(d.attr.mtype), 32'(MEM_DEVICE));
    chk("xn", {31'h0, d.attr.xn}, 32'h1);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_off();
    t_regions();
    t_special();
    t_sub();
    t_size();
    print_verdict();
  end
endmodule
`default_nettype wire
